// File: hw/riser_port_width_strap_decode.sv
// Power-on strap capture and port width decode for ten hub ports
// What this block does
// - Sample six-bit width strap at power-on
// - Straps must lie within accepted code range
// - Bits 4,3,2,0 from riser pins 3..0
// - Base code: all x4, port 2 absent
// - Bit 0 merges ports 7,8 as x8
// - Bit 1 merges ports 9,10 as x8
// - Bit 2 alone: port 3 x8, 4 absent
// - Bit 3 alone: port 5 x8, 6 absent
// - Bit 4: port 3 x16, 4-6 absent
// - Merge bits combine independently, except bit 2 or 3 with bit 4, which is flagged unsupported
// - Code 1F holds for firmware configuration
`timescale 1ns/1ps
`default_nettype none
module riser_port_width_strap_decode (
  // Clock and power-on reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Strap pins
  input wire logic [3:0] riser_id_pin_in,
  input wire logic board_strap_high_in,
  input wire logic io_module_strap_in,
  // Decoded configuration, one 3-bit width per port, port 1 in bits 2:0
  output logic [29:0] port_width_out,
  output logic [9:0] port_present_out,
  output logic [5:0] port_width_strap_out,
  output logic hold_for_firmware_config_out,
  output logic strap_unsupported_out,
  output logic config_valid_out
);
  // Synchroniser stages and capture state
  logic [5:0] sync1_q, sync1_d;
  logic [5:0] sync2_q, sync2_d;
  logic [5:0] strap_q, strap_d;
  strap_decode_pkg::state_t state_q, state_d;
  logic [29:0] width_q, width_d;
  logic [9:0] present_q, present_d;
  logic hold_q, hold_d;
  logic unsup_q, unsup_d;
  logic [5:0] raw_strap;
  logic [5:0] s;
  strap_decode_pkg::width_t w [strap_decode_pkg::NUM_PORTS];
  // Settle counter and valid flag
  logic [1:0] sync_cnt_q, sync_cnt_d;
  logic valid_q, valid_d;
  // Code classification of the captured strap
  logic is_hold;
  logic in_table;
  logic below_base;
  logic x16_with_merge;
  logic above_max;
  // Merge selections taken from the captured strap
  logic x16_3;
  logic merge_34;
  logic merge_56;
  logic merge_78;
  logic merge_910;

  // Assemble strap word from riser and board sources
  assign raw_strap = {board_strap_high_in, riser_id_pin_in[3], riser_id_pin_in[2],
                      riser_id_pin_in[1], io_module_strap_in, riser_id_pin_in[0]};
  assign s = strap_q;

  // Next state: pins pass two flops, then one capture at the first settled cycle
  always_comb begin
    sync1_d = raw_strap;
    sync2_d = sync1_q;
    strap_d = strap_q;
    state_d = state_q;
    case (state_q)
      strap_decode_pkg::ST_WAIT: begin
        // Two-cycle wait lets the synchroniser fill before capture
        if (sync_cnt_q == strap_decode_pkg::SETTLE_COUNT) begin
          strap_d = sync2_q;
          state_d = strap_decode_pkg::ST_DONE;
        end
      end
      strap_decode_pkg::ST_DONE: begin
        strap_d = strap_q;
      end
      default: begin
        state_d = strap_decode_pkg::ST_WAIT;
      end
    endcase
  end

  // Settle counter; stops at its end value so the capture fires once
  always_comb begin
    sync_cnt_d = sync_cnt_q;
    if (state_q == strap_decode_pkg::ST_WAIT && sync_cnt_q != strap_decode_pkg::SETTLE_COUNT) begin
      sync_cnt_d = sync_cnt_q + 2'h1;
    end
  end

  // Merge selections; bit 4 overrides the two upper pair merges
  assign x16_3 = s[strap_decode_pkg::BIT_X16_3];
  assign merge_34 = s[strap_decode_pkg::BIT_MERGE_3_4] && !x16_3;
  assign merge_56 = s[strap_decode_pkg::BIT_MERGE_5_6] && !x16_3;
  assign merge_78 = s[strap_decode_pkg::BIT_MERGE_7_8];
  assign merge_910 = s[strap_decode_pkg::BIT_MERGE_9_10];

  // Per-port widths; each pair decodes on its own bit, with bit 4 masking the 3-4 and 5-6 merges
  always_comb begin
    for (int i = 0; i < strap_decode_pkg::NUM_PORTS; i++) begin
      w[i] = strap_decode_pkg::WIDTH_X4;
    end
    w[1] = strap_decode_pkg::WIDTH_NONE;
    if (x16_3) begin
      w[2] = strap_decode_pkg::WIDTH_X16;
      w[3] = strap_decode_pkg::WIDTH_NONE;
      w[4] = strap_decode_pkg::WIDTH_NONE;
      w[5] = strap_decode_pkg::WIDTH_NONE;
    end
    if (merge_34) begin
      w[2] = strap_decode_pkg::WIDTH_X8;
      w[3] = strap_decode_pkg::WIDTH_NONE;
    end
    if (merge_56) begin
      w[4] = strap_decode_pkg::WIDTH_X8;
      w[5] = strap_decode_pkg::WIDTH_NONE;
    end
    // Lower merges apply regardless of the upper ones
    if (merge_78) begin
      w[6] = strap_decode_pkg::WIDTH_X8;
      w[7] = strap_decode_pkg::WIDTH_NONE;
    end
    if (merge_910) begin
      w[8] = strap_decode_pkg::WIDTH_X8;
      w[9] = strap_decode_pkg::WIDTH_NONE;
    end
  end

  // Classify the captured code; legal codes past the table are flagged, not guessed
  assign is_hold = (s == strap_decode_pkg::STRAP_FW_HOLD);
  assign below_base = (s < strap_decode_pkg::STRAP_BASE);
  assign x16_with_merge = x16_3 && (s[strap_decode_pkg::BIT_MERGE_5_6] || s[strap_decode_pkg::BIT_MERGE_3_4]);
  assign above_max = (s > strap_decode_pkg::STRAP_MAX);
  assign in_table = !below_base && !x16_with_merge && !above_max;

  // Decoded outputs load only in the done state; undecoded codes show no ports
  always_comb begin
    hold_d = hold_q;
    unsup_d = unsup_q;
    width_d = width_q;
    present_d = present_q;
    if (state_q == strap_decode_pkg::ST_DONE) begin
      hold_d = is_hold;
      unsup_d = !is_hold && !in_table;
      for (int i = 0; i < strap_decode_pkg::NUM_PORTS; i++) begin
        width_d[3*i +: 3] = in_table ? w[i] : strap_decode_pkg::WIDTH_NONE;
        present_d[i] = in_table && (w[i] != strap_decode_pkg::WIDTH_NONE);
      end
    end
  end

  // Valid rises on the same edge as the decoded outputs
  always_comb begin
    valid_d = (state_q == strap_decode_pkg::ST_DONE);
  end

  // Synchroniser and capture registers; reset takes constants only
  // Pins are slow level straps, so a plain two-flop chain is enough
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q <= strap_decode_pkg::STRAP_RESET;
      sync2_q <= strap_decode_pkg::STRAP_RESET;
      strap_q <= strap_decode_pkg::STRAP_RESET;
      state_q <= strap_decode_pkg::ST_WAIT;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      strap_q <= strap_d;
      state_q <= state_d;
    end
  end

  // Settle counter register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_cnt_q <= strap_decode_pkg::SETTLE_RESET;
    end else begin
      sync_cnt_q <= sync_cnt_d;
    end
  end

  // Decoded configuration registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      width_q <= strap_decode_pkg::WIDTH_RESET;
      present_q <= strap_decode_pkg::PRESENT_RESET;
      hold_q <= 1'h0;
      unsup_q <= 1'h0;
    end else begin
      width_q <= width_d;
      present_q <= present_d;
      hold_q <= hold_d;
      unsup_q <= unsup_d;
    end
  end

  // Valid register; low through reset so users ignore the zero outputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      valid_q <= 1'h0;
    end else begin
      valid_q <= valid_d;
    end
  end

  // Outputs straight from flops
  assign port_width_out = width_q;
  assign port_present_out = present_q;
  assign port_width_strap_out = strap_q;
  assign hold_for_firmware_config_out = hold_q;
  assign strap_unsupported_out = unsup_q;
  assign config_valid_out = valid_q;
endmodule : riser_port_width_strap_decode
`default_nettype wire

// File: hw/strap_decode_pkg.sv
// Constants and types for the port width strap decoder
package strap_decode_pkg;
  localparam int STRAP_W = 6;
  localparam int NUM_PORTS = 10;
  localparam int RISER_PINS = 4;
  // Strap code limits and special codes
  localparam logic [5:0] STRAP_MIN = 6'h00;
  localparam logic [5:0] STRAP_MAX = 6'h3B;
  localparam logic [5:0] STRAP_FW_HOLD = 6'h1F;
  localparam logic [5:0] STRAP_BASE = 6'h20;
  // Strap bit positions
  localparam int BIT_MERGE_7_8 = 0;
  localparam int BIT_MERGE_9_10 = 1;
  localparam int BIT_MERGE_3_4 = 2;
  localparam int BIT_MERGE_5_6 = 3;
  localparam int BIT_X16_3 = 4;
  localparam int BIT_BOARD_HIGH = 5;
  // Width encoding per port
  typedef enum logic [2:0] {
    WIDTH_NONE = 3'h0,
    WIDTH_X4 = 3'h1,
    WIDTH_X8 = 3'h2,
    WIDTH_X16 = 3'h4
  } width_t;
  // Capture sequence states
  typedef enum logic [1:0] {
    ST_WAIT = 2'h1,
    ST_DONE = 2'h2
  } state_t;
  localparam logic [5:0] STRAP_RESET = 6'h00;
  // Settle count and register values after reset
  localparam logic [1:0] SETTLE_COUNT = 2'h2;
  localparam logic [1:0] SETTLE_RESET = 2'h0;
  localparam logic [29:0] WIDTH_RESET = 30'h0;
  localparam logic [9:0] PRESENT_RESET = 10'h0;
endpackage : strap_decode_pkg

// File: sim/riser_port_width_strap_decode_tb_top.sv
// Self-checking bench for the strap decoder
`timescale 1ns/1ps
`default_nettype none
module riser_port_width_strap_decode_tb_top;
  logic clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [5:0] code = 6'h20;
  wire logic [3:0] rid;
  wire logic b5, b1;
  logic [29:0] width;
  logic [9:0] pres;
  logic [5:0] strap;
  logic hold, unsup, valid;
  logic [47:0] exp_q [$]; // Notes: strap, widths, presence, hold, unsupported
  int seed = 85;
  int miscompares = 0;
  int samples_checked = 0;
  always #2.5 clk_in = ~clk_in;
  // Design and strap pins
  strap_pin_model u_strap_pin_model (.code_in(code), .riser_id_pin_out(rid), .board_strap_high_out(b5),
    .io_module_strap_out(b1));
  riser_port_width_strap_decode u_riser_port_width_strap_decode (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .riser_id_pin_in(rid), .board_strap_high_in(b5), .io_module_strap_in(b1), .port_width_out(width),
    .port_present_out(pres), .port_width_strap_out(strap), .hold_for_firmware_config_out(hold),
    .strap_unsupported_out(unsup), .config_valid_out(valid));
  // Expected outcome; off-table codes leave all ports empty
  function automatic logic [47:0] expect_of(input logic [5:0] c);
    logic [29:0] w;
    logic [9:0] p;
    w = 30'h0;
    if (c inside {[6'h20:6'h33]}) begin
      w = {c[1] ? 6'h02 : 6'h09, c[0] ? 6'h02 : 6'h09, c[4] ? 12'h004 : {c[3] ? 6'h02 : 6'h09,
        c[2] ? 6'h02 : 6'h09}, 6'h01};
    end
    for (int i = 0; i < 10; i++) p[i] = |w[3 * i +: 3];
    return {c, w, p, c == 6'h1F, !(c == 6'h1F || c inside {[6'h20:6'h33]})};
  endfunction : expect_of
  task automatic check_result(input logic [47:0] e);
    samples_checked++;
    if ({strap, width, pres, hold, unsup} !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, {strap, width, pres, hold, unsup}, e);
    end
  endtask : check_result
  task automatic stop_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  // One power-on per code; pins scrambled once the latch has closed
  task automatic run(input logic [5:0] c);
    @(negedge clk_in);
    rst_b_in = 1'h0;
    code = c;
    exp_q.push_back(expect_of(c));
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'h1;
    repeat (4) @(negedge clk_in);
    code = 6'({$random(seed)} % 32'h3C);
    for (int n = 0; n < 20 && valid !== 1'h1; n++) @(negedge clk_in);
    if (valid !== 1'h1) begin
      miscompares++;
      stop_test();
    end
    repeat (6) @(negedge clk_in);
  endtask : run
  // Monitor takes the oldest note once the outputs settle
  always @(posedge valid) begin
    @(negedge clk_in);
    if (exp_q.size() > 0) begin
      check_result(exp_q.pop_front());
    end else begin
      miscompares++;
      $display("mismatch at %0t: result without a note", $time);
    end
  end
  // Codes 00 to 3B once each, then a few random ones
  initial begin
    for (int c = 0; c < 32'h3C; c++) run(c[5:0]);
    repeat (3) run(6'({$random(seed)} % 32'h3C));
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("mismatch at %0t: notes left unchecked", $time);
    end
    stop_test();
  end
endmodule : riser_port_width_strap_decode_tb_top
`default_nettype wire

// File: sim/strap_decode_props.sv
// Checker for the strap decoder outputs
`timescale 1ns/1ps
`default_nettype none
module strap_decode_props (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Decoded outputs
  input wire logic [29:0] port_width_out,
  input wire logic [9:0] port_present_out,
  input wire logic [5:0] port_width_strap_out,
  input wire logic hold_for_firmware_config_out,
  input wire logic strap_unsupported_out,
  input wire logic config_valid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Short views; dec marks a decoded table code
  wire logic [29:0] w = port_width_out;
  wire logic [5:0] s = port_width_strap_out;
  wire logic dec = config_valid_out & ~hold_for_firmware_config_out & ~strap_unsupported_out;
  chk_valid_delay: assert property ($rose(rst_b_in) |-> ##[3:8] config_valid_out)
    else $error("config valid late");
  chk_hold_code: assert property (config_valid_out |-> hold_for_firmware_config_out == (s == 6'h1F))
    else $error("hold flag wrong");
  chk_hold_empty: assert property (hold_for_firmware_config_out |-> port_present_out == 10'h000)
    else $error("ports set while held");
  chk_unsup_code: assert property (config_valid_out |-> strap_unsupported_out ==
    !(s == 6'h1F || s inside {[6'h20:6'h33]})) else $error("unsupported flag wrong");
  chk_base_ports: assert property (dec |-> w[5:0] == 6'h01 && port_present_out[1:0] == 2'h1)
    else $error("port 1 or 2 wrong");
  chk_merge_78: assert property (dec |-> w[23:18] == (s[0] ? 6'h02 : 6'h09))
    else $error("ports 7 and 8 wrong");
  chk_merge_910: assert property (dec |-> w[29:24] == (s[1] ? 6'h02 : 6'h09))
    else $error("ports 9 and 10 wrong");
  chk_x16_port3: assert property (dec && s[4] |-> w[17:6] == 12'h004)
    else $error("x16 layout wrong");
  chk_lanes_3to6: assert property (dec && !s[4] |-> w[17:6] ==
    {s[3] ? 6'h02 : 6'h09, s[2] ? 6'h02 : 6'h09}) else $error("ports 3 to 6 wrong");
  chk_latch_stable: assert property (config_valid_out |=> $stable(w) && $stable(s) && config_valid_out
    && $stable(port_present_out)) else $error("outputs moved after latch");
endmodule : strap_decode_props
bind riser_port_width_strap_decode strap_decode_props u_strap_decode_props (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .port_width_out(port_width_out), .port_present_out(port_present_out),
  .port_width_strap_out(port_width_strap_out), .hold_for_firmware_config_out(hold_for_firmware_config_out),
  .strap_unsupported_out(strap_unsupported_out), .config_valid_out(config_valid_out));
`default_nettype wire

// File: sim/strap_pin_model.sv
// Strap pin model: riser pull-downs, board pull-up, module bit
`timescale 1ns/1ps
`default_nettype none
module strap_pin_model (
  // Requested strap code
  input wire logic [5:0] code_in,
  // Pins toward the decoder
  output wire logic [3:0] riser_id_pin_out,
  output wire logic board_strap_high_out,
  output wire logic io_module_strap_out
);
  tri1 [3:0] pad; // Board pull-up reads an open pin as one
  wire logic [3:0] rid = {code_in[4:2], code_in[0]};
  // Riser only pulls down, never drives high
  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign pad[i] = rid[i] ? 1'hZ : 1'h0;
  end
  assign riser_id_pin_out = pad;
  // Bit 5 follows the code so low codes stay reachable
  assign board_strap_high_out = code_in[5];
  assign io_module_strap_out = code_in[1];
endmodule : strap_pin_model
`default_nettype wire
